// *** inc/seq_pkg.sv ***
// constants, register map and carrier types of the segment sequencer
package seq_pkg;
    localparam int          NSEG        = 4;
    localparam int          MIN_SEGS    = 2;
    localparam int          AW          = 16;
    localparam int          CW          = 16;
    localparam int          SW          = 14;
    // register map
    localparam logic [7:0]  CTRL_OFS    = 8'h00;
    localparam logic [7:0]  STAT_OFS    = 8'h04;
    localparam logic [1:0]  SEG_PAGE    = 2'h1;
    localparam int          PAGE_HI     = 7;
    localparam int          PAGE_LO     = 6;
    localparam int          SEL_HI      = 5;
    localparam int          SEL_LO      = 4;
    localparam int          REG_HI      = 3;
    localparam int          REG_LO      = 2;
    localparam logic [1:0]  R_CFG       = 2'h0;
    localparam logic [1:0]  R_START     = 2'h1;
    localparam logic [1:0]  R_STOP      = 2'h2;
    localparam logic [1:0]  R_COUNT     = 2'h3;
    // control bits
    localparam int          C_RUN       = 0;
    localparam int          C_TSTART    = 1;
    localparam int          C_SWEEP     = 2;
    localparam int          C_GATE      = 3;
    localparam int          C_MANUAL    = 4;
    localparam int          C_NEG       = 5;
    localparam logic [15:0] CNT_RESET   = 16'h0001;
    localparam logic [15:0] CNT_ZERO    = 16'h0000;
    localparam logic [15:0] ADDR_ZERO   = 16'h0000;
    localparam logic [15:0] STOP_RESET  = 16'h0001;

    typedef enum logic [1:0]
    {
        ADV_COUNT   = 2'h0,
        ADV_TRIG    = 2'h1,
        ADV_CNTTRIG = 2'h2
    } adv_mode_t;

    // gray along idle -> arm -> play -> hold
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'h0,
        ST_ARM  = 2'h1,
        ST_PLAY = 2'h3,
        ST_HOLD = 2'h2
    } seq_state_t;

    typedef struct packed
    {
        logic       async_adv;
        logic       level_qual;
        adv_mode_t  mode;
        logic       std_src;
        logic       defined;
    } seg_cfg_t;

    localparam seg_cfg_t CFG_RESET = '0;

    typedef struct packed
    {
        logic          rd;
        logic [AW-1:0] addr;
    } mem_req_t;
endpackage

// *** hdl/seg_sequencer.sv ***
// arbitrary waveform segment sequencer with apb register access
// Notes on behaviour
// - only arbitrary waveforms, standard sources refused
// - play first to last; first even, below last
// - last address odd, above first; else refused
// - count mode repeats 1..65535 times, then advances
// - trigger mode advances on qualified trigger
// - count plus trigger; hold last sample meanwhile
// - early trigger edge remembered until segment end
// - level trigger must stay true to end
// - sync timing finishes current cycle first
// - async timing switches at once
// - deleted segment skipped, others keep positions
// - two to four segments, ascending order
// - continuous or triggered start; sweep, gate only while stopped
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module seg_sequencer
    import seq_pkg::*;
#(
    parameter int SAMPLE_W = seq_pkg::SW
)
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    input  wire logic                trig_pin,
    output seq_pkg::mem_req_t        mem_req,
    input  wire logic [SAMPLE_W-1:0] mem_data,
    output logic [SAMPLE_W-1:0]      sample,
    output logic                     sweep_en,
    output logic                     gate_en
);
    import seq_pkg::*;

    seg_cfg_t            cfg_q   [NSEG];
    logic [AW-1:0]       start_q [NSEG];
    logic [AW-1:0]       stop_q  [NSEG];
    logic [CW-1:0]       cnt_q   [NSEG];
    seq_state_t          st_q;
    logic [1:0]          seg_q;
    logic [CW-1:0]       loops_q;
    mem_req_t            mem_req_q;
    logic                rd_d1_q;
    logic [SAMPLE_W-1:0] sample_q;
    logic                pready_q;
    logic                pslverr_q;
    logic [31:0]         prdata_q;
    logic                tstart_q;
    logic                sweep_q;
    logic                gate_q;
    logic                neg_q;
    logic                lat_q;
    logic                sync1_q;
    logic                sync2_q;
    logic                lvl_prev_q;
    logic                man_q;

    // next defined segment after cur, ascending with wrap
    function automatic logic [1:0] next_seg(input logic [1:0] cur, input logic [NSEG-1:0] m);
        logic [1:0] r;
        logic [1:0] k;
        r = cur;
        for (int i = NSEG; i >= 1; i--)
        begin
            k = cur + 2'(i);
            if (m[k])
                r = k;
        end
        return r;
    endfunction

    // ---------------- apb decode ----------------
    logic             setup;
    logic             acc;
    logic             is_seg;
    logic [1:0]       sel;
    logic [1:0]       rsel;
    logic             bad_w;
    logic             mapped;
    logic [31:0]      rd_val;
    logic [NSEG-1:0]  def_mask;
    logic             seq_ok;
    int               ndef;
    logic             running;
    seg_cfg_t         wcfg;

    assign setup   = psel && !penable;
    assign acc     = psel && penable && pready_q && !pslverr_q;
    assign is_seg  = paddr[PAGE_HI:PAGE_LO] == SEG_PAGE;
    assign sel     = paddr[SEL_HI:SEL_LO];
    assign rsel    = paddr[REG_HI:REG_LO];
    assign running = st_q != ST_IDLE;
    assign wcfg    = seg_cfg_t'(pwdata[$bits(seg_cfg_t)-1:0]);

    always_comb
    begin
        ndef   = 0;
        seq_ok = 1'b1;
        for (int i = 0; i < NSEG; i++)
        begin
            def_mask[i] = cfg_q[i].defined;
            if (cfg_q[i].defined)
            begin
                ndef = ndef + 1;
                if (start_q[i] >= stop_q[i])
                    seq_ok = 1'b0;
            end
        end
        if (ndef < MIN_SEGS)
            seq_ok = 1'b0;
    end

    always_comb
    begin
        mapped = is_seg || paddr == CTRL_OFS || paddr == STAT_OFS;
        bad_w  = 1'b0;
        rd_val = '0;
        if (paddr == CTRL_OFS)
        begin
            rd_val[C_RUN]    = running;
            rd_val[C_TSTART] = tstart_q;
            rd_val[C_SWEEP]  = sweep_q;
            rd_val[C_GATE]   = gate_q;
            rd_val[C_NEG]    = neg_q;
            // no sweep or gate while running; refused start
            if (pwdata[C_SWEEP] || pwdata[C_GATE])
                bad_w = running || pwdata[C_RUN];
            if (pwdata[C_RUN] && !running && !seq_ok)
                bad_w = 1'b1;
        end
        else if (paddr == STAT_OFS)
        begin
            rd_val[1:0] = st_q;
            rd_val[3:2] = seg_q;
            rd_val[4]   = lat_q;
            rd_val[5]   = seq_ok;
            bad_w       = 1'b1;
        end
        else if (is_seg)
        begin
            case (rsel)
                R_CFG:
                begin
                    rd_val[$bits(seg_cfg_t)-1:0] = cfg_q[sel];
                    bad_w = wcfg.std_src || wcfg.mode == 2'h3;
                end
                R_START:
                begin
                    rd_val[AW-1:0] = start_q[sel];
                    bad_w = pwdata[0];
                end
                R_STOP:
                begin
                    rd_val[AW-1:0] = stop_q[sel];
                    bad_w = !pwdata[0];
                end
                default:
                begin
                    rd_val[CW-1:0] = cnt_q[sel];
                    bad_w = pwdata[CW-1:0] == CNT_ZERO;
                end
            endcase
        end
    end

    // one access cycle, answer prepared at setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end
        else
        begin
            pready_q  <= setup;
            pslverr_q <= setup && (!mapped || (pwrite && bad_w));
            prdata_q  <= (setup && !pwrite && mapped) ? rd_val : '0;
        end
    end

    logic wr;
    assign wr = acc && pwrite;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NSEG; i++)
            begin
                cfg_q[i]   <= CFG_RESET;
                start_q[i] <= ADDR_ZERO;
                stop_q[i]  <= STOP_RESET;
                cnt_q[i]   <= CNT_RESET;
            end
        end
        else if (wr && is_seg)
        begin
            case (rsel)
                R_CFG:   cfg_q[sel]   <= wcfg;
                R_START: start_q[sel] <= pwdata[AW-1:0];
                R_STOP:  stop_q[sel]  <= pwdata[AW-1:0];
                default: cnt_q[sel]   <= pwdata[CW-1:0];
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tstart_q <= 1'b0;
            sweep_q  <= 1'b0;
            gate_q   <= 1'b0;
            neg_q    <= 1'b0;
            man_q    <= 1'b0;
        end
        else
        begin
            man_q <= wr && paddr == CTRL_OFS && pwdata[C_MANUAL];
            if (wr && paddr == CTRL_OFS)
            begin
                tstart_q <= pwdata[C_TSTART];
                sweep_q  <= pwdata[C_SWEEP];
                gate_q   <= pwdata[C_GATE];
                neg_q    <= pwdata[C_NEG];
            end
        end
    end

    // ---------------- trigger qualification ----------------
    logic lvl;
    logic edge_ev;
    assign lvl     = sync2_q ^ neg_q;
    // edge taken from pin history, so a polarity change is no edge
    assign edge_ev = (neg_q ? (lvl_prev_q && !sync2_q) : (sync2_q && !lvl_prev_q)) || man_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q    <= 1'b0;
            sync2_q    <= 1'b0;
            lvl_prev_q <= 1'b0;
        end
        else
        begin
            sync1_q    <= trig_pin;
            sync2_q    <= sync1_q;
            lvl_prev_q <= sync2_q;
        end
    end

    seg_cfg_t cur;
    logic     cyc_end;
    logic     cnt_done;
    logic     trig_ok;
    logic     adv;
    logic     to_hold;
    logic [1:0] nxt;
    logic     go;
    logic     stop_cmd;

    assign cur      = cfg_q[seg_q];
    assign cyc_end  = st_q == ST_PLAY && mem_req_q.addr == stop_q[seg_q];
    assign cnt_done = loops_q == cnt_q[seg_q] - CNT_RESET;
    assign trig_ok  = cur.level_qual ? lvl : (lat_q || edge_ev);
    assign nxt      = next_seg(seg_q, def_mask);
    assign go       = wr && paddr == CTRL_OFS && pwdata[C_RUN] && !running;
    assign stop_cmd = wr && paddr == CTRL_OFS && !pwdata[C_RUN];

    always_comb
    begin
        adv     = 1'b0;
        to_hold = 1'b0;
        case (cur.mode)
            ADV_COUNT:
                adv = cyc_end && cnt_done;
            ADV_TRIG:
                if (cur.async_adv)
                    adv = st_q == ST_PLAY && trig_ok;
                else
                    adv = cyc_end && trig_ok;
            ADV_CNTTRIG:
            begin
                adv     = (cyc_end && cnt_done && trig_ok) || (st_q == ST_HOLD && trig_ok);
                to_hold = cyc_end && cnt_done && !trig_ok;
            end
            default:
                adv = 1'b0;
        endcase
    end

    // edge remembered; a new edge wins over the clear, the advancing edge is used up
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lat_q <= 1'b0;
        else
            lat_q <= (lat_q && !adv && running)
                || (edge_ev && st_q != ST_IDLE && st_q != ST_ARM && !(adv && !lat_q));
    end

    // ---------------- sequence state machine ----------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q      <= ST_IDLE;
            seg_q     <= 2'h0;
            loops_q   <= CNT_ZERO;
            mem_req_q <= '0;
        end
        else if (stop_cmd)
        begin
            st_q      <= ST_IDLE;
            mem_req_q <= '0;
        end
        else
        begin
            case (st_q)
                ST_IDLE:
                    if (go)
                    begin
                        seg_q <= next_seg(2'h3, def_mask);
                        st_q  <= pwdata[C_TSTART] ? ST_ARM : ST_PLAY;
                        loops_q        <= CNT_ZERO;
                        mem_req_q.rd   <= !pwdata[C_TSTART];
                        mem_req_q.addr <= start_q[next_seg(2'h3, def_mask)];
                    end
                ST_ARM:
                    if (edge_ev)
                    begin
                        st_q         <= ST_PLAY;
                        mem_req_q.rd <= 1'b1;
                    end
                default:
                    if (adv)
                    begin
                        // next defined segment, wrapping to the lowest
                        seg_q          <= nxt;
                        loops_q        <= CNT_ZERO;
                        st_q           <= ST_PLAY;
                        mem_req_q.rd   <= 1'b1;
                        mem_req_q.addr <= start_q[nxt];
                    end
                    else if (to_hold || st_q == ST_HOLD)
                    begin
                        st_q         <= ST_HOLD;
                        mem_req_q.rd <= 1'b0;
                    end
                    else if (cyc_end)
                    begin
                        loops_q        <= loops_q + CNT_RESET;
                        mem_req_q.addr <= start_q[seg_q];
                    end
                    else
                        mem_req_q.addr <= mem_req_q.addr + ADDR_ZERO[AW-1:0] + AW'(1);
            endcase
        end
    end

    // ---------------- sample path ----------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_d1_q  <= 1'b0;
            sample_q <= '0;
        end
        else
        begin
            rd_d1_q <= mem_req_q.rd;
            if (rd_d1_q)
                sample_q <= mem_data;
        end
    end

    assign pready   = pready_q;
    assign pslverr  = pslverr_q;
    assign prdata   = prdata_q;
    assign mem_req  = mem_req_q;
    assign sample   = sample_q;
    assign sweep_en = sweep_q;
    assign gate_en  = gate_q;

    // ---------------- assertions ----------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_std_write;
        setup && pwrite && is_seg && rsel == R_CFG && wcfg.std_src;
    endsequence
    property p_std_refused;
        s_std_write |=> pslverr_q && pready_q;
    endproperty
    a_std_refused: assert property (p_std_refused) else $error("standard source accepted");

    property p_range;
        st_q == ST_PLAY |-> !start_q[seg_q][0] && mem_req_q.addr >= start_q[seg_q]
            && mem_req_q.addr <= stop_q[seg_q];
    endproperty
    a_range: assert property (p_range) else $error("address outside segment limits");

    property p_stop_odd;
        st_q == ST_PLAY |-> stop_q[seg_q][0] && stop_q[seg_q] > start_q[seg_q];
    endproperty
    a_stop_odd: assert property (p_stop_odd) else $error("bad stop address in play");

    property p_zero_count;
        setup && pwrite && is_seg && rsel == R_COUNT && pwdata[CW-1:0] == CNT_ZERO
            |=> pslverr_q ##1 cnt_q[$past(sel, 2)] != CNT_ZERO;
    endproperty
    a_zero_count: assert property (p_zero_count) else $error("zero count accepted");

    sequence s_hold2;
        (st_q == ST_HOLD && !stop_cmd && !adv)[*2];
    endsequence
    property p_hold;
        s_hold2 |=> $stable(sample_q) && !mem_req_q.rd;
    endproperty
    a_hold: assert property (p_hold) else $error("output moved while holding");

    property p_latch;
        edge_ev && st_q == ST_PLAY && !adv && !stop_cmd |=> lat_q;
    endproperty
    a_latch: assert property (p_latch) else $error("trigger edge not remembered");

    property p_sync;
        adv && !cur.async_adv && st_q == ST_PLAY |-> cyc_end;
    endproperty
    a_sync: assert property (p_sync) else $error("sync advance mid cycle");

    property p_async;
        st_q == ST_PLAY && cur.mode == ADV_TRIG && cur.async_adv && trig_ok && !stop_cmd
            |=> seg_q == $past(nxt) && mem_req_q.addr == start_q[seg_q];
    endproperty
    a_async: assert property (p_async) else $error("async advance delayed");

    property p_defined;
        st_q == ST_PLAY |-> cfg_q[seg_q].defined;
    endproperty
    a_defined: assert property (p_defined) else $error("undefined segment played");

    property p_nosweep;
        running |-> !sweep_q && !gate_q;
    endproperty
    a_nosweep: assert property (p_nosweep) else $error("sweep or gate while running");

    property p_wrap;
        adv && nxt <= seg_q && !stop_cmd |=> seg_q == next_seg(2'h3, def_mask)
            && loops_q == CNT_ZERO;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap to lowest segment");
endmodule

// *** sim/sample_mem_model.sv ***
// sample memory model answering one clock after each read request
`timescale 1ns/1ps
module sample_mem_model
    import seq_pkg::*;
#(
    parameter int SAMPLE_W = SW
)
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire seq_pkg::mem_req_t   mem_req,
    output logic [SAMPLE_W-1:0]      mem_data
);
    // data equals address; idle cycles invert it, so stale data matches again on every second idle cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mem_data <= '0;
        else if (mem_req.rd)
            mem_data <= mem_req.addr[SAMPLE_W-1:0];
        else
            mem_data <= ~mem_data;
    end
endmodule

// *** sim/seg_sequencer_bench.sv ***
// self-checking bench for the segment sequencer
`timescale 1ns/1ps
module seg_sequencer_bench;
    import seq_pkg::*;
    logic           pclk;
    logic           presetn;
    logic           psel;
    logic           penable;
    logic           pwrite;
    logic [7:0]     paddr;
    logic [31:0]    pwdata;
    logic           pready;
    logic [31:0]    prdata;
    logic           pslverr;
    logic           trig_pin;
    mem_req_t       mem_req;
    logic [SW-1:0]  mem_data;
    logic [SW-1:0]  sample;
    logic           sweep_en;
    logic           gate_en;
    logic [31:0]    rd_word;
    int             n_fail;
    int             n_tests;

    seg_sequencer #(.SAMPLE_W(SW)) i_seg_sequencer (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .trig_pin(trig_pin),
        .mem_req(mem_req), .mem_data(mem_data), .sample(sample), .sweep_en(sweep_en),
        .gate_en(gate_en));
    sample_mem_model #(.SAMPLE_W(SW)) i_sample_mem_model (.pclk(pclk), .presetn(presetn),
        .mem_req(mem_req), .mem_data(mem_data));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic print_verdict;
        $display("counts: %0d compared, %0d failed", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic fail_out(input string what);
        n_fail++;
        $display("[FAIL] %0t timeout: %s", $time, what);
        print_verdict();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic err);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (k >= 20)
            fail_out("apb ready");
        rd_word = prdata;
        chk({31'h0, pslverr}, {31'h0, err}, "apb error response");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
        apb(1'b1, a, d, err);
    endtask

    task automatic rd(input logic [7:0] a, input logic err);
        apb(1'b0, a, 32'h0, err);
    endtask

    function automatic logic [7:0] sa(input int n, input logic [1:0] r);
        return {SEG_PAGE, n[1:0], r, 2'b00};
    endfunction

    function automatic logic [31:0] cf(input adv_mode_t m, input logic lvl, input logic as);
        seg_cfg_t c;
        c = '{async_adv: as, level_qual: lvl, mode: m, std_src: 1'b0, defined: 1'b1};
        return {26'h0, c};
    endfunction

    task automatic seg(input int n, input logic [31:0] c, input logic [15:0] s,
                       input logic [15:0] e, input logic [15:0] cnt);
        wr(sa(n, R_START), {16'h0, s}, 1'b0);
        wr(sa(n, R_STOP), {16'h0, e}, 1'b0);
        wr(sa(n, R_COUNT), {16'h0, cnt}, 1'b0);
        wr(sa(n, R_CFG), c, 1'b0);
    endtask

    task automatic clr;
        wr(CTRL_OFS, 32'h0, 1'b0);
        for (int n = 0; n < NSEG; n++)
            wr(sa(n, R_CFG), 32'h0, 1'b0);
    endtask

    task automatic wait_addr(input logic [15:0] a, input int bound);
        int k;
        k = 0;
        do
        begin
            @(negedge pclk);
            k++;
        end
        while (!(mem_req.rd === 1'b1 && mem_req.addr === a) && k < bound);
        if (!(mem_req.rd === 1'b1 && mem_req.addr === a))
            fail_out("sample address not reached");
    endtask

    task automatic pulse;
        @(posedge pclk);
        trig_pin <= 1'b1;
        repeat (3) @(posedge pclk);
        trig_pin <= 1'b0;
    endtask

    task automatic t_regs;
        rd(sa(3, R_START), 1'b0);
        chk(rd_word, {16'h0, ADDR_ZERO}, "start reset");
        rd(sa(3, R_STOP), 1'b0);
        chk(rd_word, {16'h0, STOP_RESET}, "stop reset");
        rd(sa(3, R_COUNT), 1'b0);
        chk(rd_word, {16'h0, CNT_RESET}, "count reset");
        rd(8'h08, 1'b1);
        wr(STAT_OFS, 32'h0, 1'b1);
        wr(sa(0, R_CFG), 32'h3, 1'b1);
        wr(sa(0, R_CFG), 32'hD, 1'b1);
        wr(sa(0, R_START), 32'h1, 1'b1);
        wr(sa(0, R_STOP), 32'h2, 1'b1);
        wr(sa(0, R_COUNT), 32'h0, 1'b1);
        wr(sa(0, R_COUNT), 32'hFFFF, 1'b0);
        wr(CTRL_OFS, 32'h1, 1'b1);
        seg(0, cf(ADV_COUNT, 1'b0, 1'b0), 16'h0, 16'h1, 16'h1);
        wr(CTRL_OFS, 32'h1, 1'b1);
        seg(1, cf(ADV_COUNT, 1'b0, 1'b0), 16'h8, 16'h5, 16'h1);
        wr(CTRL_OFS, 32'h1, 1'b1);
        $display("test done: registers and refusals");
    endtask

    task automatic t_count;
        logic [15:0] q[$];
        clr();
        seg(2, cf(ADV_COUNT, 1'b0, 1'b0), 16'h10, 16'h11, 16'h1);
        seg(0, cf(ADV_COUNT, 1'b0, 1'b0), 16'h0, 16'h3, 16'h2);
        wr(CTRL_OFS, 32'h1, 1'b0);
        q = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h0, 16'h1, 16'h2, 16'h3, 16'h10, 16'h11, 16'h0};
        wait_addr(q[0], 10);
        for (int i = 1; i < q.size(); i++)
        begin
            @(negedge pclk);
            chk({16'h0, mem_req.addr}, {16'h0, q[i]}, "play order");
        end
        chk({18'h0, sample}, {18'h0, 14'h10}, "sample follows memory");
        $display("test done: count advance");
    endtask

    task automatic t_edge(input logic as);
        clr();
        seg(0, cf(ADV_TRIG, 1'b0, as), 16'h0, 16'hF, 16'h1);
        seg(1, cf(ADV_COUNT, 1'b0, 1'b0), 16'h20, 16'h21, 16'h1);
        wr(CTRL_OFS, 32'h1, 1'b0);
        wait_addr(16'h1, 10);
        pulse();
        if (as)
            wait_addr(16'h20, 10);
        else
        begin
            wait_addr(16'hF, 14);
            @(negedge pclk);
            chk({16'h0, mem_req.addr}, 32'h20, "sync advance");
        end
        $display("test done: edge advance");
    endtask

    task automatic t_hold;
        clr();
        seg(0, cf(ADV_CNTTRIG, 1'b0, 1'b0), 16'h0, 16'h3, 16'h1);
        seg(1, cf(ADV_COUNT, 1'b0, 1'b0), 16'h20, 16'h21, 16'h1);
        wr(CTRL_OFS, 32'h1, 1'b0);
        wait_addr(16'h3, 10);
        repeat (3) @(negedge pclk);
        for (int i = 0; i < 8; i++)
        begin
            @(negedge pclk);
            chk({31'h0, mem_req.rd}, 32'h0, "hold read");
            chk({18'h0, sample}, 32'h3, "hold sample");
        end
        pulse();
        wait_addr(16'h20, 12);
        wr(CTRL_OFS, 32'h11, 1'b0);
        wait_addr(16'h20, 12);
        $display("test done: count plus trigger");
    endtask

    task automatic t_level;
        clr();
        seg(0, cf(ADV_TRIG, 1'b1, 1'b0), 16'h0, 16'h7, 16'h1);
        seg(1, cf(ADV_COUNT, 1'b0, 1'b0), 16'h20, 16'h21, 16'h1);
        wr(CTRL_OFS, 32'h1, 1'b0);
        wait_addr(16'h7, 12);
        @(negedge pclk);
        chk({16'h0, mem_req.addr}, 32'h0, "no level, no advance");
        @(posedge pclk);
        trig_pin <= 1'b1;
        wait_addr(16'h20, 20);
        @(posedge pclk);
        trig_pin <= 1'b0;
        $display("test done: level advance");
    endtask

    task automatic t_modes;
        clr();
        seg(0, cf(ADV_COUNT, 1'b0, 1'b0), 16'h0, 16'h1, 16'h1);
        seg(1, cf(ADV_COUNT, 1'b0, 1'b0), 16'h2, 16'h3, 16'h1);
        wr(CTRL_OFS, 32'h1 << C_SWEEP, 1'b0);
        @(negedge pclk);
        chk({31'h0, sweep_en}, 32'h1, "sweep enable");
        wr(CTRL_OFS, 32'h1 << C_GATE, 1'b0);
        @(negedge pclk);
        chk({30'h0, gate_en, sweep_en}, 32'h2, "gate enable");
        wr(CTRL_OFS, 32'h0, 1'b0);
        wr(CTRL_OFS, 32'h5, 1'b1);
        wr(CTRL_OFS, 32'h23, 1'b0);
        rd(STAT_OFS, 1'b0);
        chk(rd_word & 32'h3, {30'h0, ST_ARM}, "armed state");
        pulse();
        @(negedge pclk);
        chk({31'h0, mem_req.rd}, 32'h0, "rising edge ignored");
        wait_addr(16'h0, 10);
        rd(STAT_OFS, 1'b0);
        chk(rd_word & 32'h3, {30'h0, ST_PLAY}, "playing state");
        wr(CTRL_OFS, 32'h9, 1'b1);
        @(negedge pclk);
        chk({30'h0, gate_en, sweep_en}, 32'h0, "no gate while running");
        wr(CTRL_OFS, 32'h0, 1'b0);
        $display("test done: run modes");
    endtask

    initial
    begin
        n_fail = 0;
        n_tests = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        trig_pin = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_count();
        t_edge(1'b0);
        t_edge(1'b1);
        t_hold();
        t_level();
        t_modes();
        print_verdict();
    end
endmodule
